// ===== rsi_top.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - lamp dark while host suspends device
// RULE2 - steady amber during enumeration after power-up
// RULE3 - auth level: steady green awaiting authentication
// RULE4 - auth success: slow green blink, swipes accepted
// RULE5 - auth failure: steady red until power cycle; fw_update with auth_fail in one cycle enters ST_FW, exited on fw_done
// RULE6 - no auth: steady green means ready
// RULE7 - good decode: green for two seconds
// RULE8 - bad decode: red for two seconds
// RULE9 - good read: two short 2 kHz bursts
// RULE10 - bad read: single buzz
// RULE11 - firmware update red, then brief off reset
// RULE12 - deliver result as HID or keystrokes
// RULE13 - rearm only after result fully sent
// RULE14 - timings from parameterised clock counters
module rsi_top
  import rsi_pkg::*;
(
  input  wire logic              CLK_SYS,
  input  wire logic              RST_B,
  input  wire rsi_pkg::rsi_link_t  LINK,
  input  wire rsi_pkg::rsi_swipe_t SWIPE,
  output logic [1:0]             LAMP,
  output logic                   BUZZ,
  output logic                   SWIPE_READY,
  output logic                   TX_HID,
  output logic                   TX_KBD,
  output logic                   SELF_RESET
);
  import rsi_pkg::*;

  rsi_state_t       st_q, st_d;
  logic [CNT_W-1:0] tmr_q, tmr_d;
  logic [CNT_W-1:0] blk_q, blk_d;
  logic             blink_q, blink_d;
  logic             txw_q, txw_d;
  logic             locked_q, locked_d;
  logic [1:0]       lamp_q, lamp_d;
  logic             rdy_q, rdy_d;
  logic             hid_q, hid_d;
  logic             kbd_q, kbd_d;
  logic             srst_q, srst_d;
  logic             bz_start, bz_double, tone;

  always_comb begin
    st_d     = st_q;
    tmr_d    = (tmr_q == '0) ? tmr_q : tmr_q - CNT_W'(1);
    txw_d    = txw_q;
    locked_d = locked_q;
    hid_d    = 1'b0;
    kbd_d    = 1'b0;
    srst_d   = 1'b0;
    bz_start = 1'b0;
    bz_double = 1'b0;
    if (SWIPE.tx_done) begin
      txw_d = 1'b0;
    end
    case (st_q)
      ST_ENUM: begin
        if (LINK.enumerated) begin
          st_d = LINK.auth_required ? ST_AUTHW : ST_READY;
        end
      end
      ST_AUTHW: begin
        if (LINK.auth_fail) begin
          st_d     = ST_LOCK; // [RULE5]
          locked_d = 1'b1;
        end else if (LINK.auth_ok) begin
          st_d = ST_READY; // [RULE4]
        end
      end
      ST_READY: begin
        if (SWIPE.swipe_done && !txw_q) begin
          bz_start  = 1'b1;
          bz_double = SWIPE.swipe_good; // [RULE9] [RULE10]
          tmr_d     = CNT_W'(IND_CYC - 1); // [RULE14]
          st_d      = SWIPE.swipe_good ? ST_GOOD : ST_BAD;
          if (SWIPE.card_has_data) begin
            txw_d = 1'b1;
            hid_d = !SWIPE.kbd_mode; // [RULE12]
            kbd_d = SWIPE.kbd_mode; // [RULE12]
          end
        end
      end
      ST_GOOD, ST_BAD: begin
        if (tmr_q == '0) begin
          st_d = ST_READY;
        end
      end
      ST_LOCK: begin
        st_d = ST_LOCK; // [RULE5]
      end
      ST_FW: begin
        if (LINK.fw_done) begin
          srst_d = 1'b1; // [RULE11]
          st_d   = ST_ENUM;
        end
      end
      default: st_d = ST_ENUM;
    endcase
    if (LINK.fw_update && !locked_q && st_q != ST_FW) begin
      st_d = ST_FW;
    end
  end

  always_comb begin
    blk_d   = blk_q - CNT_W'(1);
    blink_d = blink_q;
    if (blk_q == '0) begin
      blk_d   = CNT_W'(BLINK_CYC - 1); // [RULE14]
      blink_d = ~blink_q;
    end
    rdy_d = (st_q == ST_READY) && !txw_q && !LINK.suspended; // [RULE13]
    case (st_q)
      ST_ENUM:  lamp_d = LAMP_AMBER; // [RULE2]
      ST_AUTHW: lamp_d = LAMP_GREEN; // [RULE3]
      ST_READY: lamp_d = (LINK.auth_required && !blink_q) ? LAMP_OFF : LAMP_GREEN; // [RULE4] [RULE6]
      ST_GOOD:  lamp_d = LAMP_GREEN; // [RULE7]
      ST_BAD:   lamp_d = LAMP_RED; // [RULE8]
      ST_LOCK:  lamp_d = LAMP_RED; // [RULE5]
      ST_FW:    lamp_d = (LINK.fw_done) ? LAMP_OFF : LAMP_RED; // [RULE11]
      default:  lamp_d = LAMP_OFF;
    endcase
    if (LINK.suspended) begin
      lamp_d = LAMP_OFF; // [RULE1]
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      st_q     <= ST_ENUM;
      tmr_q    <= '0;
      blk_q    <= '0;
      blink_q  <= 1'b0;
      txw_q    <= 1'b0;
      locked_q <= 1'b0;
      lamp_q   <= LAMP_OFF;
      rdy_q    <= 1'b0;
      hid_q    <= 1'b0;
      kbd_q    <= 1'b0;
      srst_q   <= 1'b0;
    end else begin
      st_q     <= st_d;
      tmr_q    <= tmr_d;
      blk_q    <= blk_d;
      blink_q  <= blink_d;
      txw_q    <= txw_d;
      locked_q <= locked_d;
      lamp_q   <= lamp_d;
      rdy_q    <= rdy_d;
      hid_q    <= hid_d;
      kbd_q    <= kbd_d;
      srst_q   <= srst_d;
    end
  end

  rsi_buzzer u_buzzer (
    .clk    (CLK_SYS),
    .rst_b  (RST_B),
    .start  (bz_start),
    .double (bz_double),
    .tone   (tone)
  );

  assign LAMP        = lamp_q;
  assign BUZZ        = tone;
  assign SWIPE_READY = rdy_q;
  assign TX_HID      = hid_q;
  assign TX_KBD      = kbd_q;
  assign SELF_RESET  = srst_q;
endmodule // rsi_top

// ===== rsi_pkg.sv
package rsi_pkg;
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned IND_TIME_MS   = 2000;
  localparam int unsigned BLINK_HALF_MS = 500;
  localparam int unsigned BURST_MS      = 100;
  localparam int unsigned GAP_MS        = 100;
  localparam int unsigned TONE_HZ       = 2000;
  localparam int unsigned IND_CYC       = CLK_HZ / 1000 * IND_TIME_MS;
  localparam int unsigned BLINK_CYC     = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned BURST_CYC     = CLK_HZ / 1000 * BURST_MS;
  localparam int unsigned GAP_CYC       = CLK_HZ / 1000 * GAP_MS;
  localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam int unsigned CNT_W         = 27;
  localparam logic [1:0] LAMP_OFF   = 2'h0;
  localparam logic [1:0] LAMP_GREEN = 2'h1;
  localparam logic [1:0] LAMP_AMBER = 2'h2;
  localparam logic [1:0] LAMP_RED   = 2'h3;

  typedef struct packed {
    logic suspended;
    logic enumerated;
    logic auth_required;
    logic auth_ok;
    logic auth_fail;
    logic fw_update;
    logic fw_done;
  } rsi_link_t;

  typedef struct packed {
    logic swipe_done;
    logic swipe_good;
    logic card_has_data;
    logic kbd_mode;
    logic tx_done;
  } rsi_swipe_t;

  typedef enum logic [6:0] {
    ST_ENUM  = 7'h01,
    ST_AUTHW = 7'h02,
    ST_READY = 7'h04,
    ST_GOOD  = 7'h08,
    ST_BAD   = 7'h10,
    ST_LOCK  = 7'h20,
    ST_FW    = 7'h40
  } rsi_state_t;
endpackage

// ===== rsi_buzzer.sv
`timescale 1ns/1ps
module rsi_buzzer
  import rsi_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic start,
  input  wire logic double,
  output logic      tone
);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [15:0]      div_q, div_d;
  logic [1:0]       left_q, left_d;
  logic             on_q, on_d;
  logic             tone_q, tone_d;

  always_comb begin
    cnt_d  = cnt_q;
    div_d  = div_q;
    left_d = left_q;
    on_d   = on_q;
    tone_d = 1'b0;
    if (start) begin
      left_d = double ? 2'h2 : 2'h1; // [RULE9] [RULE10]
      on_d   = 1'b1;
      cnt_d  = CNT_W'(BURST_CYC - 1);
      div_d  = '0;
    end else if (left_q != 2'h0) begin
      if (on_q) begin
        if (div_q == 16'(TONE_HALF_CYC - 1)) begin
          div_d = '0;
        end else begin
          div_d = div_q + 16'h1;
        end
        tone_d = (div_q == 16'(TONE_HALF_CYC - 1)) ? ~tone_q : tone_q; // [RULE9] [RULE14]
      end
      if (cnt_q == '0) begin
        if (on_q) begin
          left_d = left_q - 2'h1;
          on_d   = 1'b0;
          cnt_d  = CNT_W'(GAP_CYC - 1);
        end else begin
          on_d  = 1'b1;
          cnt_d = CNT_W'(BURST_CYC - 1);
        end
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= '0;
      div_q  <= '0;
      left_q <= 2'h0;
      on_q   <= 1'b0;
      tone_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      div_q  <= div_d;
      left_q <= left_d;
      on_q   <= on_d;
      tone_q <= tone_d;
    end
  end

  assign tone = tone_q;
endmodule // rsi_buzzer

// ===== rsi_top_props.sv
`timescale 1ns/1ps
module rsi_props
  import rsi_pkg::*;
(
  input wire logic                CLK_SYS,
  input wire logic                RST_B,
  input wire rsi_pkg::rsi_link_t  LINK,
  input wire rsi_pkg::rsi_swipe_t SWIPE,
  input wire logic [1:0]          LAMP,
  input wire logic                SWIPE_READY,
  input wire logic                TX_HID,
  input wire logic                TX_KBD,
  input wire logic                SELF_RESET
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  logic acc;
  // swipe taken this edge
  assign acc = SWIPE.swipe_done && SWIPE_READY && !LINK.fw_update && !LINK.suspended;
  property p_susp; LINK.suspended |=> LAMP == LAMP_OFF; endproperty
  a_susp: assert property (p_susp) else $error("lamp lit");
  property p_hid; acc && SWIPE.card_has_data && !SWIPE.kbd_mode |=> TX_HID && !TX_KBD; endproperty
  a_hid: assert property (p_hid) else $error("no hid");
  property p_kbd; acc && SWIPE.card_has_data && SWIPE.kbd_mode |=> TX_KBD && !TX_HID; endproperty
  a_kbd: assert property (p_kbd) else $error("no kbd");
  property p_cause; TX_HID || TX_KBD |-> $past(SWIPE.swipe_done) && $past(SWIPE_READY); endproperty
  a_cause: assert property (p_cause) else $error("tx no swipe");
  // lamp is registered from the state, so the indication shows two edges after the swipe
  property p_good; acc && SWIPE.swipe_good ##1 !LINK.suspended |=> LAMP == LAMP_GREEN; endproperty
  a_good: assert property (p_good) else $error("not green");
  property p_bad; acc && !SWIPE.swipe_good ##1 !LINK.suspended |=> LAMP == LAMP_RED; endproperty
  a_bad: assert property (p_bad) else $error("not red");
  property p_busy; TX_HID || TX_KBD |=> !SWIPE_READY [*2]; endproperty
  a_busy: assert property (p_busy) else $error("rearm early");
  property p_fw; SELF_RESET |-> $past(LINK.fw_done) ##1 !SELF_RESET; endproperty
  a_fw: assert property (p_fw) else $error("bad self reset");
endmodule // rsi_props
bind rsi_top rsi_props u_props (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .LINK(LINK), .SWIPE(SWIPE), .LAMP(LAMP),
  .SWIPE_READY(SWIPE_READY), .TX_HID(TX_HID), .TX_KBD(TX_KBD), .SELF_RESET(SELF_RESET));

// ===== rsi_host.sv
`timescale 1ns/1ps
module rsi_host (
  input  wire logic       clk,
  input  wire logic       tx_hid,
  input  wire logic       tx_kbd,
  input  wire logic [3:0] dly,
  output logic            tx_done
);
  int n = -1;
  initial tx_done = 1'b0;
  // transfer completes dly+1 cycles after a send request
  always @(posedge clk) begin
    tx_done <= (n == 0);
    if (tx_hid || tx_kbd)
      n <= int'(dly);
    else if (n >= 0)
      n <= n - 1;
  end
endmodule // rsi_host

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(s,e,a) begin checks++; if ((a) !== (e)) begin mismatches++; $display("ERROR %s exp %h got %h", s, e, a); end end
module testbench;
  import rsi_pkg::*;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  rsi_link_t  lk = '0;
  rsi_swipe_t sw = '0;
  rsi_swipe_t sw_in;
  logic [3:0] dly = '0;
  logic [1:0] lamp;
  logic       done, buzz, rdy, hid, kbd, srst;
  int         mismatches = 0;
  int         checks = 0;
  int         cycles = 0;
  int         n;
  initial forever #12.5 clk = ~clk;
  always_comb begin
    sw_in = sw;
    sw_in.tx_done = done;
  end
  rsi_top u_dut (.CLK_SYS(clk), .RST_B(rst_b), .LINK(lk), .SWIPE(sw_in), .LAMP(lamp), .BUZZ(buzz),
    .SWIPE_READY(rdy), .TX_HID(hid), .TX_KBD(kbd), .SELF_RESET(srst));
  rsi_host u_host (.clk(clk), .tx_hid(hid), .tx_kbd(kbd), .dly(dly), .tx_done(done));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic cyc(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic rst();
    @(posedge clk);
    rst_b <= 1'b0;
    lk <= '0;
    sw <= '0;
    cyc(20);
    @(posedge clk);
    rst_b <= 1'b1;
    cyc(1);
  endtask
  task automatic swipe(logic g, logic d, logic k);
    @(posedge clk);
    dly <= 4'($urandom);
    sw <= '{1'b1, g, d, k, 1'b0};
    @(posedge clk);
    sw.swipe_done <= 1'b0;
    #1;
  endtask
  initial begin
    void'($urandom(63390));
    rst();
    `CHK("lamp", LAMP_AMBER, lamp)
    @(posedge clk);
    lk.suspended <= 1'b1;
    cyc(2);
    `CHK("lamp", LAMP_OFF, lamp)
    @(posedge clk);
    lk.suspended <= 1'b0;
    lk.enumerated <= 1'b1;
    cyc(3);
    `CHK("lamp", LAMP_GREEN, lamp)
    `CHK("ready", 1'b1, rdy)
    swipe(1'b1, 1'b1, 1'b0);
    `CHK("hid", 1'b1, hid)
    `CHK("lamp", LAMP_GREEN, lamp)
    swipe(1'b0, 1'b1, 1'b0);
    `CHK("hid", 1'b0, hid)
    `CHK("lamp", LAMP_GREEN, lamp)
    n = 0;
    while (buzz !== 1'b1 && n < 2 * TONE_HALF_CYC) begin
      @(posedge clk);
      n++;
    end
    `CHK("buzz", 1'b1, buzz)
    $display("test 1 done");
    rst();
    @(posedge clk);
    lk.auth_required <= 1'b1;
    lk.enumerated <= 1'b1;
    cyc(3);
    `CHK("lamp", LAMP_GREEN, lamp)
    `CHK("ready", 1'b0, rdy)
    @(posedge clk);
    lk.auth_fail <= 1'b1;
    @(posedge clk);
    lk.auth_fail <= 1'b0;
    lk.fw_update <= 1'b1;
    cyc(3);
    `CHK("lamp", LAMP_RED, lamp)
    `CHK("ready", 1'b0, rdy)
    $display("test 2 done");
    rst();
    @(posedge clk);
    lk.auth_required <= 1'b1;
    lk.enumerated <= 1'b1;
    cyc(2);
    @(posedge clk);
    lk.auth_ok <= 1'b1;
    @(posedge clk);
    lk.auth_ok <= 1'b0;
    cyc(3);
    `CHK("ready", 1'b1, rdy)
    swipe(1'b0, 1'b1, 1'b1);
    `CHK("kbd", 1'b1, kbd)
    cyc(1);
    `CHK("lamp", LAMP_RED, lamp)
    $display("test 3 done");
    rst();
    @(posedge clk);
    lk.enumerated <= 1'b1;
    lk.fw_update <= 1'b1;
    cyc(3);
    `CHK("lamp", LAMP_RED, lamp)
    @(posedge clk);
    lk.fw_done <= 1'b1;
    @(posedge clk);
    lk.fw_done <= 1'b0;
    lk.fw_update <= 1'b0;
    #1;
    `CHK("self reset", 1'b1, srst)
    `CHK("lamp", LAMP_OFF, lamp)
    cyc(1);
    `CHK("lamp", LAMP_AMBER, lamp)
    $display("test 4 done");
    complete_run();
  end
endmodule // testbench
